//--- hdl/sasm_detect.sv
// sasm_detect: turns raw fault conditions into per-flag set requests
// assumes: condition inputs synchronous to clk_sys_in
`timescale 1ns/1ns
`default_nettype none
module sasm_detect
	import sasm_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic link_enable_in,
	input wire logic mode_66b_in,
	input wire logic [SASM_LANES-1:0] lane_fifo_err_in,
	input wire logic serial_pll_locked_in,
	input wire logic data_encoding_state_in,
	input wire logic realign_in,
	input wire logic sysref_realign_in,
	input wire logic div_ab_match_cd_in,
	sasm_if.det evt
);
	typedef struct packed {
		logic link_en_d;
	} sasm_det_s;
	sasm_det_s st_ff;
	sasm_det_s nxt_st;
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_st = st_ff;
		nxt_st.link_en_d = link_enable_in;
	end
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		evt.set_evt = SASM_ZERO;
		evt.lane_evt = lane_fifo_err_in;
		evt.set_evt[SASM_BIT_FIFO] = |lane_fifo_err_in;
		evt.set_evt[SASM_BIT_SPLL] = !serial_pll_locked_in;
		if (!mode_66b_in) begin
			evt.set_evt[SASM_BIT_LINK] = link_enable_in && !data_encoding_state_in;
		end else begin
			evt.set_evt[SASM_BIT_LINK] = link_enable_in && (!st_ff.link_en_d || realign_in);
		end
		evt.set_evt[SASM_BIT_REALIGN] = sysref_realign_in;
		evt.set_evt[SASM_BIT_CLK] = !div_ab_match_cd_in;
	end
endmodule : sasm_detect
`default_nettype wire

//--- hdl/sasm_if.sv
// sasm_if: fault event bundle between the alarm core and its condition detector
// assumes: both ends clocked by the system clock
`timescale 1ns/1ns
`default_nettype none
interface sasm_if;
	import sasm_pkg::*;
	logic [SASM_DW-1:0] set_evt;
	logic [SASM_LANES-1:0] lane_evt;
	modport det (output set_evt, output lane_evt);
	modport core (input set_evt, input lane_evt);
endinterface : sasm_if
`default_nettype wire

//--- hdl/sasm_pkg.sv
// sasm_pkg: register map, field positions and reset values of the alarm block
// assumes: one 25 MHz system clock; registers reached over a plain strobe port
package sasm_pkg;
	localparam int SASM_AW = 10;
	localparam int SASM_DW = 8;
	localparam int SASM_LANES = 8;
	localparam logic [SASM_AW-1:0] SASM_ADDR_SUMMARY = 10'h2C0;
	localparam logic [SASM_AW-1:0] SASM_ADDR_STATUS = 10'h2C1;
	localparam logic [SASM_AW-1:0] SASM_ADDR_MASK = 10'h2C2;
	localparam logic [SASM_AW-1:0] SASM_ADDR_LANE = 10'h2C4;
	localparam logic [SASM_AW-1:0] SASM_ADDR_CTRL = 10'h2C8;
	localparam int SASM_BIT_FIFO = 5;
	localparam int SASM_BIT_SPLL = 4;
	localparam int SASM_BIT_LINK = 3;
	localparam int SASM_BIT_REALIGN = 2;
	localparam int SASM_BIT_RSVD = 1;
	localparam int SASM_BIT_CLK = 0;
	localparam logic [SASM_DW-1:0] SASM_STATUS_RST = 8'h3F;
	localparam logic [SASM_DW-1:0] SASM_MASK_RST = 8'h3F;
	localparam logic [SASM_DW-1:0] SASM_LANE_RST = 8'hFF;
	localparam logic [SASM_DW-1:0] SASM_EVENT_BITS = 8'h3D;
	localparam logic [SASM_DW-1:0] SASM_ZERO = 8'h00;
	localparam int SASM_CTRL_LINK_EN = 0;
	localparam int SASM_CTRL_MODE66 = 1;
	localparam int SASM_CTRL_PINSEL = 2;
	localparam logic [SASM_DW-1:0] SASM_CTRL_RST = 8'h00;
	localparam logic [SASM_DW-1:0] SASM_CTRL_BITS = 8'h07;
endpackage : sasm_pkg

//--- hdl/sasm_top.sv
// sasm_top: sticky alarm flags, mask, summary alarm and register port
// assumes: single 25 MHz clock, plain strobe register port, inputs synchronous
// Summary of operation
// - any active lane FIFO under/overflow sets the lane FIFO flag, bit 5
// - serial PLL out of lock sets the PLL unlock flag, bit 4
// - 8B/10B: link enabled but not in data state sets link flag, bit 3
// - 64B/66B: link flag set at link start and on any realignment while link is enabled
// - SYSREF clock realignment sets the realign flag, bit 2
// - channel divider mismatch sets the clock fault flag, bit 0
// - writing one clears a flag; writing zero leaves it unchanged
// - reset presets every status flag to one
// - flags other than clock fault are meaningless while link is disabled
// - mask bit one keeps its flag out of the summary; masks reset to one
// - summary alarm is one when any unmasked flag is set; may drive pin
// - clearing lane FIFO flag also clears all per-lane FIFO flags
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module sasm_top
	import sasm_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic [SASM_AW-1:0] reg_addr_in,
	input wire logic [SASM_DW-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [SASM_DW-1:0] reg_rdata_out,
	input wire logic [SASM_LANES-1:0] lane_fifo_err_in,
	input wire logic serial_pll_locked_in,
	input wire logic data_encoding_state_in,
	input wire logic realign_in,
	input wire logic sysref_realign_in,
	input wire logic div_ab_match_cd_in,
	output logic link_enable_out,
	output logic alarm_irq_out,
	output logic calibration_status_pin_out
);
	typedef struct packed {
		logic [SASM_DW-1:0] status;
		logic [SASM_DW-1:0] mask;
		logic [SASM_LANES-1:0] lane;
		logic [SASM_DW-1:0] ctrl;
		logic [SASM_DW-1:0] rdata;
	} sasm_state_s;
	sasm_state_s st_ff;
	sasm_state_s nxt_st;
	logic summary;
	logic wr_status;
	logic wr_mask;
	logic wr_lane;
	logic wr_ctrl;
	logic clr_lanes;
	sasm_if evt_bus ();
	////////////////////////////////////////////////////////////////////////
	function automatic logic hit(input logic [SASM_AW-1:0] a, input logic [SASM_AW-1:0] b);
		hit = (a == b);
	endfunction : hit
	////////////////////////////////////////////////////////////////////////
	sasm_detect u_detect (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.link_enable_in(st_ff.ctrl[SASM_CTRL_LINK_EN]),
		.mode_66b_in(st_ff.ctrl[SASM_CTRL_MODE66]),
		.lane_fifo_err_in(lane_fifo_err_in),
		.serial_pll_locked_in(serial_pll_locked_in),
		.data_encoding_state_in(data_encoding_state_in),
		.realign_in(realign_in),
		.sysref_realign_in(sysref_realign_in),
		.div_ab_match_cd_in(div_ab_match_cd_in),
		.evt(evt_bus.det)
	);
	////////////////////////////////////////////////////////////////////////
	assign summary = |(st_ff.status & ~st_ff.mask & SASM_EVENT_BITS);
	assign wr_status = reg_wr_in && hit(reg_addr_in, SASM_ADDR_STATUS);
	assign wr_mask = reg_wr_in && hit(reg_addr_in, SASM_ADDR_MASK);
	assign wr_lane = reg_wr_in && hit(reg_addr_in, SASM_ADDR_LANE);
	assign wr_ctrl = reg_wr_in && hit(reg_addr_in, SASM_ADDR_CTRL);
	assign clr_lanes = wr_status && reg_wdata_in[SASM_BIT_FIFO];
	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_st = st_ff;
		if (wr_status) begin
			nxt_st.status = st_ff.status & ~(reg_wdata_in & SASM_EVENT_BITS);
		end
		nxt_st.status = nxt_st.status | (evt_bus.set_evt & SASM_EVENT_BITS);
		if (clr_lanes) begin
			nxt_st.lane = SASM_ZERO;
		end else if (wr_lane) begin
			nxt_st.lane = st_ff.lane & ~reg_wdata_in;
		end
		nxt_st.lane = nxt_st.lane | evt_bus.lane_evt;
		if (wr_mask) begin
			nxt_st.mask = reg_wdata_in;
		end
		if (wr_ctrl) begin
			nxt_st.ctrl = reg_wdata_in & SASM_CTRL_BITS;
		end
		nxt_st.rdata = SASM_ZERO;
		if (reg_rd_in) begin
			case (reg_addr_in)
				SASM_ADDR_SUMMARY: nxt_st.rdata = {7'h00, summary};
				SASM_ADDR_STATUS: nxt_st.rdata = st_ff.status;
				SASM_ADDR_MASK: nxt_st.rdata = st_ff.mask;
				SASM_ADDR_LANE: nxt_st.rdata = st_ff.lane;
				SASM_ADDR_CTRL: nxt_st.rdata = st_ff.ctrl;
				default: nxt_st.rdata = SASM_ZERO;
			endcase
		end
	end
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_ff.status <= SASM_STATUS_RST;
			st_ff.mask <= SASM_MASK_RST;
			st_ff.lane <= SASM_LANE_RST;
			st_ff.ctrl <= SASM_CTRL_RST;
			st_ff.rdata <= SASM_ZERO;
		end else begin
			st_ff <= nxt_st;
		end
	end
	////////////////////////////////////////////////////////////////////////
	assign reg_rdata_out = st_ff.rdata;
	assign link_enable_out = st_ff.ctrl[SASM_CTRL_LINK_EN];
	assign alarm_irq_out = summary;
	assign calibration_status_pin_out = summary && st_ff.ctrl[SASM_CTRL_PINSEL];
endmodule : sasm_top
`default_nettype wire

//--- tb/sasm_checker.sv
// sasm_checker: port-level assertions for the alarm block
// assumes: bound into sasm_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module sasm_checker
	import sasm_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic [SASM_AW-1:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [SASM_DW-1:0] reg_rdata_out,
	input wire logic [SASM_LANES-1:0] lane_fifo_err_in,
	input wire logic serial_pll_locked_in,
	input wire logic sysref_realign_in,
	input wire logic div_ab_match_cd_in,
	input wire logic link_enable_out,
	input wire logic alarm_irq_out,
	input wire logic calibration_status_pin_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_rds; reg_rd_in && reg_addr_in == SASM_ADDR_STATUS; endsequence
	////////////////////////////////////////////////////////////////////////////////
	property p_rz; !$past(reg_rd_in) |-> reg_rdata_out == SASM_ZERO; endproperty
	a_rz: assert property (p_rz) else $error("rdata not idle");
	property p_sum; reg_rd_in && reg_addr_in == SASM_ADDR_SUMMARY |=> reg_rdata_out == {7'h00, $past(alarm_irq_out)}; endproperty
	a_sum: assert property (p_sum) else $error("summary read");
	property p_pin; calibration_status_pin_out |-> alarm_irq_out; endproperty
	a_pin: assert property (p_pin) else $error("pin without alarm");
	property p_le; $changed(link_enable_out) |-> $past(reg_wr_in && reg_addr_in == SASM_ADDR_CTRL); endproperty
	a_le: assert property (p_le) else $error("link enable moved");
	property p_fifo; (|lane_fifo_err_in) ##1 s_rds |=> reg_rdata_out[SASM_BIT_FIFO]; endproperty
	a_fifo: assert property (p_fifo) else $error("fifo flag");
	property p_spll; !serial_pll_locked_in ##1 s_rds |=> reg_rdata_out[SASM_BIT_SPLL]; endproperty
	a_spll: assert property (p_spll) else $error("pll flag");
	property p_ra; sysref_realign_in ##1 s_rds |=> reg_rdata_out[SASM_BIT_REALIGN]; endproperty
	a_ra: assert property (p_ra) else $error("realign flag");
	property p_clk; !div_ab_match_cd_in ##1 s_rds |=> reg_rdata_out[SASM_BIT_CLK]; endproperty
	a_clk: assert property (p_clk) else $error("clock flag");
endmodule : sasm_checker
bind sasm_top sasm_checker i_chk (.clk_sys_in, .rst_b_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
	.reg_rdata_out, .lane_fifo_err_in, .serial_pll_locked_in, .sysref_realign_in,
	.div_ab_match_cd_in, .link_enable_out, .alarm_irq_out, .calibration_status_pin_out);
`default_nettype wire

//--- tb/test_serdes_alarm_status_mask.sv
// test_serdes_alarm_status_mask: register sequences against the alarm block
// assumes: sasm_top with checker bound, 25 MHz clock
`timescale 1ns/1ns
`default_nettype none
module test_serdes_alarm_status_mask;
	import sasm_pkg::*;
	logic clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0, re = 1'h0, le, irq, pin;
	logic [9:0] a = 10'h000;
	logic [7:0] wd = 8'h00, rdata, bm [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
	logic [4:0] f = 5'h00;
	int n_mismatch = 0, checked = 0;
	always #20 clk = ~clk;
	sasm_top i_dut (.clk_sys_in(clk), .rst_b_in(rst_b), .reg_addr_in(a), .reg_wdata_in(wd),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .lane_fifo_err_in({5'h00, f[0], 2'h0}),
		.serial_pll_locked_in(!f[1]), .data_encoding_state_in(!f[2]), .realign_in(re),
		.sysref_realign_in(f[3]), .div_ab_match_cd_in(!f[4]), .link_enable_out(le),
		.alarm_irq_out(irq), .calibration_status_pin_out(pin));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic w(input logic [9:0] ad, input logic [7:0] d);
		@(posedge clk) begin a <= ad; wd <= d; wr <= 1'h1; end
		@(posedge clk) wr <= 1'h0;
	endtask : w
	task automatic r(input logic [9:0] ad, input logic [7:0] e);
		@(posedge clk) begin a <= ad; rd <= 1'h1; end
		@(posedge clk) rd <= 1'h0;
		#1 chk($sformatf("reg %h", ad), rdata, e);
	endtask : r
	task automatic complete_run;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'h1;
		r(SASM_ADDR_STATUS, SASM_STATUS_RST);
		r(SASM_ADDR_MASK, SASM_MASK_RST);
		r(SASM_ADDR_LANE, SASM_LANE_RST);
		r(SASM_ADDR_SUMMARY, 8'h00);
		w(10'h2C3, 8'hFF);
		r(10'h2C3, 8'h00);
		w(SASM_ADDR_CTRL, 8'h05);
		#1 chk("link_enable", {7'h00, le}, 8'h01);
		w(SASM_ADDR_STATUS, 8'h3F);
		r(SASM_ADDR_STATUS, 8'h02);
		r(SASM_ADDR_LANE, 8'h00);
		for (int k = 0; k < 5; k++) begin
			@(posedge clk) f <= 5'h01 << k;
			w(SASM_ADDR_STATUS, bm[k]);
			r(SASM_ADDR_STATUS, 8'h02 | bm[k]);
			@(posedge clk) f <= 5'h00;
			w(SASM_ADDR_MASK, 8'h3F ^ bm[k]);
			#1 chk("irq pin", {6'h00, pin, irq}, 8'h03);
			w(SASM_ADDR_STATUS, 8'h00);
			r(SASM_ADDR_STATUS, 8'h02 | bm[k]);
			w(SASM_ADDR_STATUS, bm[k]);
			r(SASM_ADDR_STATUS, 8'h02);
			#1 chk("irq pin", {6'h00, pin, irq}, 8'h00);
		end
		w(SASM_ADDR_CTRL, 8'h00);
		w(SASM_ADDR_STATUS, 8'h3F);
		w(SASM_ADDR_CTRL, 8'h07);
		r(SASM_ADDR_STATUS, 8'h0A);
		w(SASM_ADDR_STATUS, 8'h08);
		r(SASM_ADDR_STATUS, 8'h02);
		@(posedge clk) re <= 1'h1;
		@(posedge clk) re <= 1'h0;
		r(SASM_ADDR_STATUS, 8'h0A);
		w(SASM_ADDR_MASK, 8'h36);
		r(SASM_ADDR_SUMMARY, 8'h01);
		#1 chk("irq pin", {6'h00, pin, irq}, 8'h03);
		w(SASM_ADDR_CTRL, 8'h03);
		#1 chk("irq pin", {6'h00, pin, irq}, 8'h01);
		complete_run();
	end
	initial begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		complete_run();
	end
endmodule : test_serdes_alarm_status_mask
`default_nettype wire
